// ### hdl/level_sync.sv
`timescale 1ns/1ps

module level_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      hold_r <= '0;
    end
    else
    begin
      meta_r <= async_in;
      hold_r <= meta_r;
    end
  end

  assign sync_out = hold_r;

endmodule : level_sync

// ### hdl/voltage_trip_detect_control.sv
// Function
// - detector powered and running only while detector_enable is set.
// - with stop-in-idle set, detector halts in idle; otherwise it keeps running.
// - direction one: voltage at or above trip point is an event.
// - direction zero: voltage at or below trip point is an event.
// - event sets interrupt flag; enabled flag raises the interrupt request.
// - read-only flag shows one when band-gap voltage is stable.
// - reference-stable flag readable; no flag set while it reads zero.
// - trip level code 1111 selects the external sense input.
// - trip level codes 0 to 14 select internal trip point of that number.
// - unimplemented control bits ignore writes and read as zero.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "vtd_cfg.svh"

module voltage_trip_detect_control
#(
  parameter int SETTLE_CYCLES = `VTD_SETTLE_CYC,
  parameter int CNT_W         = 16
)
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  // register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [15:0]     reg_rdata,
  // power management
  input  wire logic            idle_mode,
  // analog front end status, asynchronous
  input  wire logic            cmp_at_or_above,
  input  wire logic            cmp_at_or_below,
  input  wire logic            bandgap_stable,
  input  wire logic            reference_stable,
  // analog front end control
  output logic                 detector_power_en,
  output logic                 external_sense_select,
  output logic      [3:0]      trip_point_select,
  output logic                 direction_select,
  // interrupt
  output logic                 irq
);

  // reset release
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // analog status synchronisers
  logic [3:0] async_status;
  logic [3:0] sync_status;
  logic       above_s;
  logic       below_s;
  logic       bandgap_ok_s;
  logic       reference_ok_s;

  assign async_status = {reference_stable, bandgap_stable, cmp_at_or_below, cmp_at_or_above};

  level_sync
  #(
    .WIDTH (4)
  )
  u_status_sync
  (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in (async_status),
    .sync_out (sync_status)
  );

  assign above_s        = sync_status[0];
  assign below_s        = sync_status[1];
  assign bandgap_ok_s   = sync_status[2];
  assign reference_ok_s = sync_status[3];

  // register decode
  logic hit_control;
  logic hit_status;
  logic hit_clear;
  logic hit_enable;
  logic wr_control;
  logic wr_clear;
  logic wr_enable;

  assign hit_control = (reg_addr == `VTD_ADDR_CONTROL);
  assign hit_status  = (reg_addr == `VTD_ADDR_STATUS);
  assign hit_clear   = (reg_addr == `VTD_ADDR_CLEAR);
  assign hit_enable  = (reg_addr == `VTD_ADDR_ENABLE);
  assign wr_control  = reg_wr && hit_control;
  assign wr_clear    = reg_wr && hit_clear;
  assign wr_enable   = reg_wr && hit_enable;

  // control register, stored bits only
  vtd_pkg::word_t control_r;
  vtd_pkg::word_t control_nxt;

  assign control_nxt = wr_control ? (reg_wdata & `VTD_CONTROL_WMASK) : control_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      control_r <= `VTD_CONTROL_RESET;
    else
      control_r <= control_nxt;
  end

  logic            cfg_enable;
  logic            cfg_stop_idle;
  logic            cfg_direction;
  vtd_pkg::level_t cfg_level;

  // enable and stop-in-idle act at the write edge, so power follows within one cycle
  assign cfg_enable    = control_nxt[`VTD_BIT_ENABLE];
  assign cfg_stop_idle = control_nxt[`VTD_BIT_STOP_IDLE];
  assign cfg_direction = control_r[`VTD_BIT_DIRECTION];
  assign cfg_level     = control_r[`VTD_LEVEL_MSB:`VTD_LEVEL_LSB];

  // a trip point or direction change re-blanks the comparator
  logic cfg_changed;

  assign cfg_changed = wr_control
                       && ((control_nxt[`VTD_BIT_DIRECTION] != cfg_direction)
                       || (control_nxt[`VTD_LEVEL_MSB:`VTD_LEVEL_LSB] != cfg_level));

  // detector sequencing
  vtd_pkg::det_state_e state_r;
  vtd_pkg::det_state_e state_nxt;
  logic [CNT_W-1:0]    settle_r;
  logic [CNT_W-1:0]    settle_nxt;
  logic                idle_stop;
  logic                settle_done;

  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);

  assign idle_stop   = cfg_stop_idle && idle_mode;
  assign settle_done = (settle_r == '0);

  always_comb
  begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    case (state_r)
      vtd_pkg::ST_OFF:
      begin
        if (cfg_enable)
        begin
          state_nxt  = idle_stop ? vtd_pkg::ST_HALTED : vtd_pkg::ST_SETTLE;
          settle_nxt = SETTLE_LOAD;
        end
      end
      vtd_pkg::ST_SETTLE:
      begin
        if (!cfg_enable)
          state_nxt = vtd_pkg::ST_OFF;
        else if (idle_stop)
          state_nxt = vtd_pkg::ST_HALTED;
        else if (cfg_changed)
          settle_nxt = SETTLE_LOAD;
        else if (settle_done)
          state_nxt = vtd_pkg::ST_ARMED;
        else
          settle_nxt = settle_r - CNT_W'(1);
      end
      vtd_pkg::ST_ARMED:
      begin
        if (!cfg_enable)
          state_nxt = vtd_pkg::ST_OFF;
        else if (idle_stop)
          state_nxt = vtd_pkg::ST_HALTED;
        else if (cfg_changed)
        begin
          state_nxt  = vtd_pkg::ST_SETTLE;
          settle_nxt = SETTLE_LOAD;
        end
      end
      vtd_pkg::ST_HALTED:
      begin
        if (!cfg_enable)
          state_nxt = vtd_pkg::ST_OFF;
        else if (!idle_stop)
        begin
          state_nxt  = vtd_pkg::ST_SETTLE;
          settle_nxt = SETTLE_LOAD;
        end
      end
      default:
      begin
        state_nxt  = vtd_pkg::ST_OFF;
        settle_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= vtd_pkg::ST_OFF;
      settle_r <= '0;
    end
    else
    begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // analog control outputs, registered from next state
  logic power_nxt;

  assign power_nxt = (state_nxt == vtd_pkg::ST_SETTLE) || (state_nxt == vtd_pkg::ST_ARMED);

  logic            power_r;
  logic            ext_sel_r;
  vtd_pkg::level_t trip_sel_r;
  logic            dir_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_r    <= 1'b0;
      ext_sel_r  <= 1'b0;
      trip_sel_r <= 4'h0;
      dir_r      <= 1'b0;
    end
    else
    begin
      power_r    <= power_nxt;
      ext_sel_r  <= (control_nxt[`VTD_LEVEL_MSB:`VTD_LEVEL_LSB] == `VTD_LEVEL_EXTERNAL);
      trip_sel_r <= control_nxt[`VTD_LEVEL_MSB:`VTD_LEVEL_LSB];
      dir_r      <= control_nxt[`VTD_BIT_DIRECTION];
    end
  end

  assign detector_power_en     = power_r;
  assign external_sense_select = ext_sel_r;
  assign trip_point_select     = trip_sel_r;
  assign direction_select      = dir_r;

  // detection, level sensitive so a slow crossing is never missed
  logic crossing;
  logic trip_event;
  logic ref_ok_d_r;
  logic ref_ready_event;

  assign crossing   = cfg_direction ? above_s : below_s;
  assign trip_event = (state_r == vtd_pkg::ST_ARMED) && reference_ok_s && crossing;

  assign ref_ready_event = reference_ok_s && !ref_ok_d_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ref_ok_d_r <= 1'b0;
    else
      ref_ok_d_r <= reference_ok_s;
  end

  // sticky event flags, set wins over clear
  logic [`VTD_EVT_WIDTH-1:0] evt_set;
  logic [`VTD_EVT_WIDTH-1:0] evt_clr;
  logic [`VTD_EVT_WIDTH-1:0] status_r;
  logic [`VTD_EVT_WIDTH-1:0] status_nxt;
  logic [`VTD_EVT_WIDTH-1:0] irq_en_r;
  logic [`VTD_EVT_WIDTH-1:0] irq_en_nxt;

  assign evt_set    = {ref_ready_event, trip_event};
  assign evt_clr    = wr_clear ? reg_wdata[`VTD_EVT_WIDTH-1:0] : '0;
  assign status_nxt = (status_r & ~evt_clr) | evt_set;
  assign irq_en_nxt = wr_enable ? reg_wdata[`VTD_EVT_WIDTH-1:0] : irq_en_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r <= `VTD_EVT_RESET;
      irq_en_r <= `VTD_EVT_RESET;
    end
    else
    begin
      status_r <= status_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // interrupt follows the next flag state so it lines up with a status read
  logic irq_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_nxt & irq_en_nxt);
  end

  assign irq = irq_r;

  // read path
  vtd_pkg::word_t control_view;
  vtd_pkg::word_t status_view;
  vtd_pkg::word_t enable_view;
  vtd_pkg::word_t read_sel;

  always_comb
  begin
    control_view                     = control_r;
    control_view[`VTD_BIT_BANDGAP]   = bandgap_ok_s;
    control_view[`VTD_BIT_REFERENCE] = reference_ok_s;
  end

  assign status_view = {{(16 - `VTD_EVT_WIDTH){1'b0}}, status_r};
  assign enable_view = {{(16 - `VTD_EVT_WIDTH){1'b0}}, irq_en_r};

  // clear register is write only, unmapped addresses read zero
  assign read_sel = hit_control ? control_view :
                    hit_status  ? status_view  :
                    hit_enable  ? enable_view  :
                    16'h0000;

  vtd_pkg::word_t rdata_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 16'h0000;
    else
      rdata_r <= reg_rd ? read_sel : 16'h0000;
  end

  assign reg_rdata = rdata_r;

endmodule : voltage_trip_detect_control

// ### hdl/vtd_cfg.svh
`ifndef VTD_CFG_SVH
`define VTD_CFG_SVH

// register word addresses
`define VTD_ADDR_CONTROL    4'h0
`define VTD_ADDR_STATUS     4'h4
`define VTD_ADDR_CLEAR      4'h8
`define VTD_ADDR_ENABLE     4'hC

// control register field positions
`define VTD_BIT_ENABLE      15
`define VTD_BIT_STOP_IDLE   13
`define VTD_BIT_DIRECTION   7
`define VTD_BIT_BANDGAP     6
`define VTD_BIT_REFERENCE   5
`define VTD_LEVEL_MSB       3
`define VTD_LEVEL_LSB       0

// control register reset value and writable positions
`define VTD_CONTROL_RESET   16'h0000
`define VTD_CONTROL_WMASK   16'hA08F

// trip level code that selects the external sense input
`define VTD_LEVEL_EXTERNAL  4'hF

// event bits of status, clear and enable registers
`define VTD_EVT_TRIP        0
`define VTD_EVT_REF_READY   1
`define VTD_EVT_WIDTH       2
`define VTD_EVT_RESET       2'h0

// analog settle blanking after power-up or a change of trip point
`define VTD_CLK_PERIOD_NS   10
`define VTD_SETTLE_NS       1000
`define VTD_SETTLE_CYC      ((`VTD_SETTLE_NS + `VTD_CLK_PERIOD_NS - 1) / `VTD_CLK_PERIOD_NS)

`endif

// ### hdl/vtd_pkg.sv
package vtd_pkg;

  typedef logic [15:0] word_t;
  typedef logic [3:0]  addr_t;
  typedef logic [3:0]  level_t;

  typedef enum logic [1:0]
  {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_ARMED  = 2'b10,
    ST_HALTED = 2'b11
  } det_state_e;

endpackage : vtd_pkg

// ### verif/voltage_trip_detect_control_chk.sv
`timescale 1ns/1ps
module voltage_trip_detect_control_chk
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // detector side
  input wire logic        idle_mode,
  input wire logic        bandgap_stable,
  input wire logic        reference_stable,
  input wire logic        detector_power_en,
  input wire logic        external_sense_select,
  input wire logic [3:0]  trip_point_select,
  input wire logic        direction_select,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == 4'h0;

  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_ctrl_unused: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & 16'h5F10) == 16'h0000)
    else $error("unused control bits read as one");
  a_power_drop: assert property (ctl_wr && !reg_wdata[15] |=> !detector_power_en)
    else $error("detector powered while disabled");
  a_power_rise: assert property (ctl_wr && reg_wdata[15] && !idle_mode |=> detector_power_en)
    else $error("detector not powered after enable");
  a_dir_copy: assert property (ctl_wr |=> direction_select == $past(reg_wdata[7]))
    else $error("direction output wrong");
  a_level_copy: assert property (ctl_wr |=> trip_point_select == $past(reg_wdata[3:0]) && external_sense_select == ($past(reg_wdata[3:0]) == 4'hF))
    else $error("trip level outputs wrong");
  a_bandgap_flag: assert property (($stable(bandgap_stable))[*4] ##0 (reg_rd && reg_addr == 4'h0) |=> reg_rdata[6] == $past(bandgap_stable))
    else $error("band-gap flag wrong");
  a_ref_flag: assert property (($stable(reference_stable))[*4] ##0 (reg_rd && reg_addr == 4'h0) |=> reg_rdata[5] == $past(reference_stable))
    else $error("reference flag wrong");
  a_irq_mask: assert property (reg_wr && reg_addr == 4'hC && reg_wdata[1:0] == 2'h0 |=> ##1 !irq)
    else $error("interrupt high while masked");
endmodule : voltage_trip_detect_control_chk

bind voltage_trip_detect_control voltage_trip_detect_control_chk chk (.ref_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .idle_mode, .bandgap_stable,
  .reference_stable, .detector_power_en, .external_sense_select, .trip_point_select,
  .direction_select, .irq);

// ### verif/voltage_trip_detect_control_tb.sv
`timescale 1ns/1ps
module voltage_trip_detect_control_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        idle_mode = 1'b0;
  logic        above = 1'b0;
  logic        below = 1'b0;
  logic        bandgap = 1'b0;
  logic        refst = 1'b0;
  logic        power_en;
  logic        ext_sel;
  logic [3:0]  point;
  logic        dir;
  logic        irq;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] v;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  integer      seed = 32'h61ed;

  always #5 ref_clk = ~ref_clk;

  // short blanking keeps the run brief
  voltage_trip_detect_control #(.SETTLE_CYCLES(4)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .idle_mode(idle_mode), .cmp_at_or_above(above),
    .cmp_at_or_below(below), .bandgap_stable(bandgap), .reference_stable(refst),
    .detector_power_en(power_en), .external_sense_select(ext_sel),
    .trip_point_select(point), .direction_select(dir), .irq(irq));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // waits past the edge so outputs have landed
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : pause

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  always @(posedge ref_clk)
  begin
    rd_d   <= reg_rd;
    cycles <= cycles + 1;
  end

  // read data stand for one cycle only
  always @(negedge ref_clk)
  begin
    if (rd_d && exp_q.size() > 0)
      chk(reg_rdata, exp_q.pop_front());
    if (cycles > 3000)
    begin
      n_mismatch++;
      final_report;
    end
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    pause(4);
    rd(4'h0, 16'h0000);
    rd(4'h4, 16'h0000);
    rd(4'hC, 16'h0000);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    rd(4'h8, 16'h0000);
    bandgap <= 1'b1;
    wr(4'h0, 16'h5F10);
    rd(4'h0, 16'h0040);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'hA0CF);
    $display("registers done");
    for (int i = 0; i < 16; i++)
    begin
      v = 16'h8000 | 16'(i) | (16'($random(seed)) & 16'h0080);
      wr(4'h0, v);
      pause(1);
      chk({10'h0, dir, ext_sel, point}, {10'h0, v[7], v[3:0] == 4'hF, v[3:0]});
    end
    $display("levels done");
    wr(4'h0, 16'h8085);
    above <= 1'b1;
    pause(20);
    rd(4'h4, 16'h0000);
    refst <= 1'b1;
    pause(20);
    rd(4'h4, 16'h0003);
    wr(4'hC, 16'h0003);
    pause(2);
    chk({15'h0, irq}, 16'h0001);
    above <= 1'b0;
    wr(4'hC, 16'h0000);
    pause(3);
    chk({15'h0, irq}, 16'h0000);
    rd(4'h4, 16'h0003);
    wr(4'hC, 16'h0001);
    wr(4'h8, 16'h0003);
    pause(3);
    rd(4'h4, 16'h0000);
    pause(1);
    chk({15'h0, irq}, 16'h0000);
    $display("rising trip done");
    wr(4'h0, 16'h8005);
    above <= 1'b1;
    pause(20);
    rd(4'h4, 16'h0000);
    below <= 1'b1;
    pause(5);
    rd(4'h4, 16'h0001);
    pause(1);
    chk({15'h0, irq}, 16'h0001);
    below <= 1'b0;
    pause(4);
    wr(4'h8, 16'h0001);
    $display("falling trip done");
    wr(4'h0, 16'hA005);
    idle_mode <= 1'b1;
    pause(3);
    chk({15'h0, power_en}, 16'h0000);
    below <= 1'b1;
    pause(10);
    rd(4'h4, 16'h0000);
    idle_mode <= 1'b0;
    pause(3);
    chk({15'h0, power_en}, 16'h0001);
    pause(20);
    rd(4'h4, 16'h0001);
    below <= 1'b0;
    pause(4);
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h8005);
    idle_mode <= 1'b1;
    pause(3);
    chk({15'h0, power_en}, 16'h0001);
    idle_mode <= 1'b0;
    $display("idle done");
    wr(4'h0, 16'h0005);
    pause(1);
    chk({15'h0, power_en}, 16'h0000);
    below <= 1'b1;
    pause(20);
    rd(4'h4, 16'h0000);
    pause(3);
    $display("disable done");
    final_report;
  end
endmodule : voltage_trip_detect_control_tb
